// ### idt_pkg.sv
// Shared constants and types for the instruction decode and timing block.
// Assumes a single core clock that also serves as the oscillator clock.
package idt_pkg;

  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BITSEL_W = 3;
  localparam int OSC_PER_CYCLE = 4;
  localparam int PHASE_W = 2;
  localparam logic [1:0] PH_READ = 2'h0;
  localparam logic [1:0] PH_LATCH = 2'h1;
  localparam logic [1:0] PH_MODIFY = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;

  // ****************************************
  // Instruction word fields
  // ****************************************
  localparam int OP6_LSB = 8;
  localparam int OP4_LSB = 10;
  localparam int DEST_BIT = 7;
  localparam int BITSEL_LSB = 7;
  localparam int PTRSEL_BIT = 2;
  localparam logic [INSTR_W-1:0] RESET_INSTR = 14'h0000;
  localparam logic [ADDR_W-1:0] IND_REG0_ADDR = 7'h00;
  localparam logic [ADDR_W-1:0] IND_REG1_ADDR = 7'h01;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [5:0] OP_MOVWF = 6'h00;
  localparam logic [5:0] OP_CLRF = 6'h01;
  localparam logic [5:0] OP_SUBWF = 6'h02;
  localparam logic [5:0] OP_DECF = 6'h03;
  localparam logic [5:0] OP_IORWF = 6'h04;
  localparam logic [5:0] OP_ANDWF = 6'h05;
  localparam logic [5:0] OP_XORWF = 6'h06;
  localparam logic [5:0] OP_ADDWF = 6'h07;
  localparam logic [5:0] OP_MOVF = 6'h08;
  localparam logic [5:0] OP_COMF = 6'h09;
  localparam logic [5:0] OP_INCF = 6'h0A;
  localparam logic [5:0] OP_DECSKIP = 6'h0B;
  localparam logic [5:0] OP_SWAPF = 6'h0E;
  localparam logic [5:0] OP_INCSKIP = 6'h0F;
  localparam logic [5:0] OP_LSLF = 6'h35;
  localparam logic [5:0] OP_LSRF = 6'h36;
  localparam logic [5:0] OP_ASRF = 6'h37;
  localparam logic [5:0] OP_SUBWFB = 6'h3B;
  localparam logic [5:0] OP_ADDWFC = 6'h3D;
  localparam logic [5:0] OP_MOVLW = 6'h30;
  localparam logic [5:0] OP_RETLIT = 6'h34;
  localparam logic [5:0] OP_IORLW = 6'h38;
  localparam logic [5:0] OP_ANDLW = 6'h39;
  localparam logic [5:0] OP_XORLW = 6'h3A;
  localparam logic [5:0] OP_SUBLW = 6'h3C;
  localparam logic [5:0] OP_ADDLW = 6'h3E;
  localparam logic [3:0] OP_BITCLR = 4'h4;
  localparam logic [3:0] OP_BITSET = 4'h5;
  localparam logic [3:0] OP_SKIPCLR = 4'h6;
  localparam logic [3:0] OP_SKIPSET = 4'h7;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETINT = 14'h0009;
  localparam logic [13:0] OP_CALLACC = 14'h000A;
  localparam logic [13:0] OP_BRANCHACC = 14'h000B;

  typedef enum logic [1:0] {CL_BYTE, CL_BIT, CL_LIT} idt_class_t;
  typedef enum logic [3:0] {
    CT_NONE, CT_CALL, CT_CALLACC, CT_RET, CT_RETLIT, CT_RETINT,
    CT_JUMP, CT_RELBR, CT_BRACC, CT_PTR
  } idt_ctrl_t;

endpackage

// ### idt_fields_if.sv
// Carrier for the decoded fields of one instruction word.
// Assumes the splitter is purely combinational on the held word.
`timescale 1ns/10ps
interface idt_fields_if;
  logic [idt_pkg::INSTR_W-1:0] word;
  idt_pkg::idt_class_t cls;
  idt_pkg::idt_ctrl_t ctrl;
  logic [5:0] op6;
  logic [3:0] op4;
  logic dest;
  logic [idt_pkg::ADDR_W-1:0] fAddr;
  logic [idt_pkg::BITSEL_W-1:0] bitSel;
  logic [idt_pkg::DATA_W-1:0] lit;
  logic ptrSel;
  logic [1:0] ptrMode;
  modport split (input word, output cls, ctrl, op6, op4, dest, fAddr, bitSel, lit, ptrSel,
    ptrMode);
  modport core (output word, input cls, ctrl, op6, op4, dest, fAddr, bitSel, lit, ptrSel,
    ptrMode);
endinterface

// ### idt_field_split.sv
// Splits a 14-bit instruction word into its format fields and class.
// Assumes the word is held stable by the timing core for a whole cycle.
`timescale 1ns/10ps
module idt_field_split (
  idt_fields_if.split fld
);

  logic [5:0] top6;

  assign top6 = fld.word[13:8];
  assign fld.op6 = top6;
  assign fld.op4 = fld.word[13:10];
  assign fld.dest = fld.word[idt_pkg::DEST_BIT];
  assign fld.fAddr = fld.word[idt_pkg::ADDR_W-1:0];
  assign fld.bitSel = fld.word[idt_pkg::BITSEL_LSB +: idt_pkg::BITSEL_W];
  assign fld.lit = fld.word[idt_pkg::DATA_W-1:0];
  assign fld.ptrSel = fld.word[idt_pkg::PTRSEL_BIT];
  assign fld.ptrMode = fld.word[1:0];

  // ****************************************
  // Classification
  // ****************************************
  always_comb begin
    fld.cls = idt_pkg::CL_LIT;
    fld.ctrl = idt_pkg::CT_NONE;
    if (fld.word[13:12] == 2'h1) begin
      fld.cls = idt_pkg::CL_BIT;
    end else if (fld.word[13:12] == 2'h0 && fld.word[13:7] != 7'h00) begin
      fld.cls = idt_pkg::CL_BYTE;
    end else if (top6 == idt_pkg::OP_LSLF || top6 == idt_pkg::OP_LSRF ||
                 top6 == idt_pkg::OP_ASRF || top6 == idt_pkg::OP_SUBWFB ||
                 top6 == idt_pkg::OP_ADDWFC) begin
      fld.cls = idt_pkg::CL_BYTE;
    end else if (fld.word[13:12] == 2'h2) begin
      fld.ctrl = fld.word[11] ? idt_pkg::CT_JUMP : idt_pkg::CT_CALL;
    end else if (fld.word[13:9] == 5'h19) begin
      fld.ctrl = idt_pkg::CT_RELBR;
    end else if (top6 == idt_pkg::OP_RETLIT) begin
      fld.ctrl = idt_pkg::CT_RETLIT;
    end else if (fld.word == idt_pkg::OP_RETURN) begin
      fld.ctrl = idt_pkg::CT_RET;
    end else if (fld.word == idt_pkg::OP_RETINT) begin
      fld.ctrl = idt_pkg::CT_RETINT;
    end else if (fld.word == idt_pkg::OP_CALLACC) begin
      fld.ctrl = idt_pkg::CT_CALLACC;
    end else if (fld.word == idt_pkg::OP_BRANCHACC) begin
      fld.ctrl = idt_pkg::CT_BRACC;
    end else if (fld.word[13:4] == 10'h001) begin
      fld.ctrl = idt_pkg::CT_PTR;
    end
  end

endmodule

// ### idt_decode_timing.sv
// Instruction decode and cycle timing core: four-phase cycle, read-modify-write
// of file registers, accumulator, and extra-cycle control.
// Assumes program memory presents the next word on instrWord at all times and
// the file memory returns fileRdData one clock after fileRdEn.
//
// Notes on behaviour
// - Each instruction is one 14-bit word holding opcode and all operands.
// - Opcodes fall into byte, bit and literal/control groups.
// - Instructions not listed as exceptions take exactly one instruction cycle.
// - Direct call and call via accumulator take two cycles.
// - Plain return, return with literal and interrupt return take two cycles.
// - Jumps, branches and taken skips take two cycles.
// - Indirect access while pointer addresses program memory adds one cycle.
// - One instruction cycle lasts four oscillator clocks.
// - File register instructions read, modify, then store to the destination.
// - The addressed register is read even if only written.
// - Destination bit 0 stores to accumulator, 1 stores to file register.
// - File address field is 7 bits, 0x00 to 0x7F in current bank.
// - Bit field selects one bit of the 8-bit file register.
// - Don't-care bits never change execution; the CLRF dest-0 address field can still add an indirect cycle.
// - Pointer select field chooses indirect pointer 0 or 1.
// - Mode field picks pre/post increment/decrement of chosen pointer.
// - Byte format: six-bit opcode, destination bit 7, address bits 6..0.
// - Bit format: four-bit opcode, three-bit bit number, seven-bit address.
// - Literal ops take low eight bits against the accumulator.
`timescale 1ns/10ps
module idt_decode_timing (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Program memory
  input wire logic [idt_pkg::INSTR_W-1:0] instrWord,
  output logic fetchNext,
  output logic flushFetch,
  output idt_pkg::idt_ctrl_t flowKind,
  // File register memory
  input wire logic [idt_pkg::DATA_W-1:0] fileRdData,
  input wire logic [1:0] ptrInProg,
  output logic fileRdEn,
  output logic fileWrEn,
  output logic [idt_pkg::ADDR_W-1:0] fileAddr,
  output logic [idt_pkg::DATA_W-1:0] fileWrData,
  // Indirect pointer adjust
  output logic ptrAdjust,
  output logic ptrSel,
  output logic [1:0] ptrMode,
  // Core state
  output logic [idt_pkg::DATA_W-1:0] accum,
  output logic cycleEnd
);

  typedef enum logic [1:0] {ST_RUN, ST_EXTRA, ST_NOP} idt_state_t;

  idt_fields_if fld ();
  idt_field_split u_split (.fld(fld));

  idt_state_t state_r;
  logic [idt_pkg::PHASE_W-1:0] phase_r;
  logic [idt_pkg::INSTR_W-1:0] instr_r;
  logic [idt_pkg::DATA_W-1:0] rd_r;
  logic [idt_pkg::DATA_W-1:0] res_r;
  logic [idt_pkg::DATA_W-1:0] accum_r;
  logic toFile_r;
  logic toAcc_r;
  logic skip_r;
  logic usesFile;
  logic indirect;
  logic needExtra;
  logic twoCycle;
  logic commit;
  logic qEnd;
  logic [idt_pkg::DATA_W-1:0] bitMask;

  assign fld.word = instr_r;

  // ****************************************
  // Phase divider
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_r <= idt_pkg::PH_READ;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign qEnd = (phase_r == idt_pkg::PH_WRITE);
  assign cycleEnd = qEnd;

  // ****************************************
  // Decode terms
  // ****************************************
  assign usesFile = (fld.cls != idt_pkg::CL_LIT);
  assign indirect = usesFile && (fld.fAddr == idt_pkg::IND_REG0_ADDR ||
                                 fld.fAddr == idt_pkg::IND_REG1_ADDR);
  // Pointer number is the low address bit for indirect file operands
  assign ptrSel = (fld.ctrl == idt_pkg::CT_PTR) ? fld.ptrSel : fld.fAddr[0];
  assign needExtra = (state_r == ST_RUN) &&
                     ((indirect && ptrInProg[fld.fAddr[0]]) ||
                      (fld.ctrl == idt_pkg::CT_PTR && ptrInProg[fld.ptrSel]));
  assign twoCycle = (fld.ctrl inside {idt_pkg::CT_CALL, idt_pkg::CT_CALLACC}) ||
                    (fld.ctrl inside {idt_pkg::CT_RET, idt_pkg::CT_RETLIT,
                                      idt_pkg::CT_RETINT}) ||
                    (fld.ctrl inside {idt_pkg::CT_JUMP, idt_pkg::CT_RELBR,
                                      idt_pkg::CT_BRACC}) || skip_r;
  // Results land only at a cycle end with no extra pass pending, never in a NOP slot
  assign commit = qEnd && !needExtra && state_r != ST_NOP;
  assign bitMask = 8'h01 << fld.bitSel;

  // ****************************************
  // Read phase
  // ****************************************
  // A NOP slot reads nothing so the discarded word has no side effect
  assign fileRdEn = usesFile && phase_r == idt_pkg::PH_READ &&
                    state_r != ST_NOP;
  assign fileAddr = fld.fAddr;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_r <= 8'h00;
    end else if (phase_r == idt_pkg::PH_LATCH) begin
      rd_r <= fileRdData;
    end
  end

  // ****************************************
  // Modify phase
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      res_r <= 8'h00;
      toFile_r <= 1'b0;
      toAcc_r <= 1'b0;
      skip_r <= 1'b0;
    end else if (phase_r == idt_pkg::PH_MODIFY) begin
      res_r <= rd_r;
      toFile_r <= 1'b0;
      toAcc_r <= 1'b0;
      skip_r <= 1'b0;
      if (fld.cls == idt_pkg::CL_BYTE) begin
        toFile_r <= fld.dest;
        toAcc_r <= !fld.dest;
        unique case (fld.op6)
          idt_pkg::OP_MOVWF: res_r <= accum_r;
          idt_pkg::OP_CLRF: res_r <= 8'h00;
          idt_pkg::OP_SUBWF, idt_pkg::OP_SUBWFB: res_r <= rd_r - accum_r;
          idt_pkg::OP_ADDWF, idt_pkg::OP_ADDWFC: res_r <= rd_r + accum_r;
          idt_pkg::OP_IORWF: res_r <= rd_r | accum_r;
          idt_pkg::OP_ANDWF: res_r <= rd_r & accum_r;
          idt_pkg::OP_XORWF: res_r <= rd_r ^ accum_r;
          idt_pkg::OP_COMF: res_r <= ~rd_r;
          idt_pkg::OP_DECF: res_r <= rd_r - 8'h01;
          idt_pkg::OP_INCF: res_r <= rd_r + 8'h01;
          idt_pkg::OP_SWAPF: res_r <= {rd_r[3:0], rd_r[7:4]};
          idt_pkg::OP_LSLF: res_r <= {rd_r[6:0], 1'b0};
          idt_pkg::OP_LSRF: res_r <= {1'b0, rd_r[7:1]};
          idt_pkg::OP_ASRF: res_r <= {rd_r[7], rd_r[7:1]};
          idt_pkg::OP_DECSKIP: begin
            res_r <= rd_r - 8'h01;
            skip_r <= (rd_r == 8'h01);
          end
          idt_pkg::OP_INCSKIP: begin
            res_r <= rd_r + 8'h01;
            skip_r <= (rd_r == 8'hFF);
          end
          default: res_r <= rd_r;
        endcase
      end else if (fld.cls == idt_pkg::CL_BIT) begin
        unique case (fld.op4)
          idt_pkg::OP_BITCLR: begin
            res_r <= rd_r & ~bitMask;
            toFile_r <= 1'b1;
          end
          idt_pkg::OP_BITSET: begin
            res_r <= rd_r | bitMask;
            toFile_r <= 1'b1;
          end
          idt_pkg::OP_SKIPCLR: skip_r <= ((rd_r & bitMask) == 8'h00);
          idt_pkg::OP_SKIPSET: skip_r <= ((rd_r & bitMask) != 8'h00);
          default: skip_r <= 1'b0;
        endcase
      end else if (fld.ctrl == idt_pkg::CT_RETLIT || fld.ctrl == idt_pkg::CT_NONE) begin
        toAcc_r <= (fld.ctrl == idt_pkg::CT_RETLIT) || (fld.word[13:12] == 2'h3);
        unique case (fld.op6)
          idt_pkg::OP_IORLW: res_r <= fld.lit | accum_r;
          idt_pkg::OP_ANDLW: res_r <= fld.lit & accum_r;
          idt_pkg::OP_XORLW: res_r <= fld.lit ^ accum_r;
          idt_pkg::OP_SUBLW: res_r <= fld.lit - accum_r;
          idt_pkg::OP_ADDLW: res_r <= fld.lit + accum_r;
          idt_pkg::OP_MOVLW, idt_pkg::OP_RETLIT: res_r <= fld.lit;
          default: begin
            res_r <= accum_r;
            toAcc_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Write phase
  // ****************************************
  assign fileWrEn = commit && toFile_r;
  assign fileWrData = res_r;
  assign ptrAdjust = commit && fld.ctrl == idt_pkg::CT_PTR;
  assign ptrMode = fld.ptrMode;
  assign accum = accum_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      accum_r <= 8'h00;
    end else if (commit && toAcc_r) begin
      accum_r <= res_r;
    end
  end

  // ****************************************
  // Cycle sequencing
  // ****************************************
  // fetchNext pulses at every cycle end with no extra pass pending; before a NOP slot the word it passes is discarded
  assign fetchNext = qEnd && !needExtra;
  assign flushFetch = commit && twoCycle && !skip_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_RUN;
      instr_r <= idt_pkg::RESET_INSTR;
      flowKind <= idt_pkg::CT_NONE;
    end else if (qEnd) begin
      if (needExtra) begin
        state_r <= ST_EXTRA;
      end else if (state_r != ST_NOP && twoCycle) begin
        state_r <= ST_NOP;
        instr_r <= idt_pkg::RESET_INSTR;
        flowKind <= skip_r ? idt_pkg::CT_NONE : fld.ctrl;
      end else begin
        state_r <= ST_RUN;
        instr_r <= instrWord;
        flowKind <= idt_pkg::CT_NONE;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_cycle_end_spacing;
    !qEnd [*3] ##1 qEnd;
  endsequence

  a_cycle_four_clocks: assert property (@(posedge ref_clk) disable iff (rst)
    qEnd |=> s_cycle_end_spacing) else $error("instruction cycle is not four clocks");

  a_read_before_write: assert property (@(posedge ref_clk) disable iff (rst)
    fileWrEn |-> $past(fileRdEn, 3)) else $error("file write without earlier read");

  a_dest_accum_only: assert property (@(posedge ref_clk) disable iff (rst)
    (commit && fld.cls == idt_pkg::CL_BYTE && !fld.dest) |-> !fileWrEn ##1
    accum == $past(res_r)) else $error("destination zero did not go to accumulator");

  a_indirect_extra: assert property (@(posedge ref_clk) disable iff (rst)
    (qEnd && needExtra) |-> !fetchNext ##4 (fetchNext && state_r == ST_EXTRA))
    else $error("indirect program access lacks one extra cycle");

  a_skip_nop_slot: assert property (@(posedge ref_clk) disable iff (rst)
    (commit && skip_r) |=> (state_r == ST_NOP && !fileRdEn) [*4])
    else $error("skip did not run a no-operation cycle");

  a_flow_flush: assert property (@(posedge ref_clk) disable iff (rst)
    (commit && fld.ctrl inside {idt_pkg::CT_JUMP, idt_pkg::CT_CALL, idt_pkg::CT_RET})
    |-> flushFetch ##1 (state_r == ST_NOP)) else $error("control flow without flush");

  a_single_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    (fetchNext && !twoCycle && state_r == ST_RUN) |=> state_r == ST_RUN)
    else $error("plain instruction took more than one cycle");

  a_two_cycle_call: assert property (@(posedge ref_clk) disable iff (rst)
    (commit && fld.ctrl == idt_pkg::CT_CALLACC) |-> ##4 (fetchNext && state_r == ST_NOP))
    else $error("call via accumulator not two cycles");

  a_ret_two_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    (commit && fld.ctrl == idt_pkg::CT_RETLIT) |=> state_r == ST_NOP && accum == $past(res_r))
    else $error("return with literal not two cycles");

  // The discarded slot must leave no trace on memory, pointers or fetch
  a_nop_no_effect: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_NOP) |-> (!fileWrEn && !ptrAdjust && !flushFetch))
    else $error("no-operation slot had a side effect");

  a_skip_no_flush: assert property (@(posedge ref_clk) disable iff (rst)
    (commit && skip_r) |-> (fetchNext && !flushFetch))
    else $error("taken skip flushed or withheld the fetch");

  a_bit_only_one: assert property (@(posedge ref_clk) disable iff (rst)
    (commit && fld.cls == idt_pkg::CL_BIT && fileWrEn) |->
    ((fileWrData ^ rd_r) & ~bitMask) == 8'h00)
    else $error("bit operation changed an unselected bit");

  a_literal_load: assert property (@(posedge ref_clk) disable iff (rst)
    (commit && fld.cls == idt_pkg::CL_LIT && fld.op6 == idt_pkg::OP_MOVLW) |=>
    accum == $past(fld.lit))
    else $error("literal load did not reach accumulator");

  a_flow_kind_shown: assert property (@(posedge ref_clk) disable iff (rst)
    flushFetch |=> flowKind == $past(fld.ctrl))
    else $error("flushed control flow kind not shown");

endmodule

// ### idt_mem_model.sv
// Partner model: program memory and file register memory facing the decode core.
// Assumes the core fetches on fetchNext and samples file data one clock after fileRdEn.
`timescale 1ns/10ps
module idt_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Program side
  input wire logic fetchNext,
  output logic [idt_pkg::INSTR_W-1:0] instrWord,
  // File side
  input wire logic fileRdEn,
  input wire logic fileWrEn,
  input wire logic [idt_pkg::ADDR_W-1:0] fileAddr,
  input wire logic [idt_pkg::DATA_W-1:0] fileWrData,
  output logic [idt_pkg::DATA_W-1:0] fileRdData
);
  logic [idt_pkg::INSTR_W-1:0] prog [0:511];
  logic [idt_pkg::DATA_W-1:0] fileMem [0:127];
  int pc;
  initial begin
    foreach (prog[i]) prog[i] = 14'h0000;
    foreach (fileMem[i]) fileMem[i] = 8'h00;
    fileRdData = 8'h00;
  end
  // Sequential only: targets of control flow are not followed
  assign instrWord = prog[pc[8:0]];
  always @(posedge ref_clk) begin
    if (rst) pc <= 0;
    else if (fetchNext) pc <= pc + 1;
  end
  // Data holds for one clock only, then turns over so a late sample shows
  always @(posedge ref_clk) begin
    if (fileRdEn) fileRdData <= fileMem[fileAddr];
    else fileRdData <= ~fileRdData;
    if (fileWrEn) fileMem[fileAddr] <= fileWrData;
  end
endmodule

// ### test_instruction_decode_timing.sv
// Self-checking bench for the decode and timing core.
// Assumes the memory model fetches sequentially; each step runs one word, then a filler.
`timescale 1ns/10ps
module test_instruction_decode_timing;
  localparam logic [13:0] POISON_WORD = {idt_pkg::OP_MOVLW, 8'hEE};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] ptrInProg = 2'b00;
  logic [13:0] instrWord;
  logic [7:0] fileRdData, fileWrData, accum;
  logic [6:0] fileAddr;
  logic [1:0] ptrMode, seenMode;
  logic fetchNext, flushFetch, fileRdEn, fileWrEn, ptrAdjust, ptrSel, cycleEnd, seenSel;
  idt_pkg::idt_ctrl_t flowKind, seenFlow;
  int failures = 0;
  int comparisons = 0;
  int gap, rdCnt, wrCnt, flushCnt, adjCnt, endCnt;

  initial forever #5 ref_clk = ~ref_clk;

  idt_decode_timing idt_decode_timing_i (.ref_clk(ref_clk), .rst(rst), .instrWord(instrWord),
    .fetchNext(fetchNext), .flushFetch(flushFetch), .flowKind(flowKind),
    .fileRdData(fileRdData), .ptrInProg(ptrInProg), .fileRdEn(fileRdEn), .fileWrEn(fileWrEn),
    .fileAddr(fileAddr), .fileWrData(fileWrData), .ptrAdjust(ptrAdjust), .ptrSel(ptrSel),
    .ptrMode(ptrMode), .accum(accum), .cycleEnd(cycleEnd));
  idt_mem_model idt_mem_model_i (.ref_clk(ref_clk), .rst(rst), .fetchNext(fetchNext),
    .instrWord(instrWord), .fileRdEn(fileRdEn), .fileWrEn(fileWrEn), .fileAddr(fileAddr),
    .fileWrData(fileWrData), .fileRdData(fileRdData));

  // ****************************************
  // Checks and report
  // ****************************************
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_data(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ****************************************
  // Slot runner
  // ****************************************
  // Samples at the falling edge so combinational pulses are read where settled
  task automatic run_slot();
    logic f;
    do begin
      @(negedge ref_clk);
      gap++;
      rdCnt += int'(fileRdEn === 1'b1);
      wrCnt += int'(fileWrEn === 1'b1);
      flushCnt += int'(flushFetch === 1'b1);
      endCnt += int'(cycleEnd === 1'b1);
      if (flowKind !== idt_pkg::CT_NONE) seenFlow = flowKind;
      if (ptrAdjust === 1'b1) begin
        adjCnt++;
        seenSel = ptrSel;
        seenMode = ptrMode;
      end
      f = fetchNext;
    end while (f !== 1'b1 && gap < 40);
    @(posedge ref_clk);
    #1;
    if (gap >= 40) begin
      failures++;
      close_out();
    end
  endtask
  task automatic issue(input logic [13:0] w, input logic [13:0] fill, input int expGap,
    input int expFetch = 1);
    int p;
    p = idt_mem_model_i.pc;
    idt_mem_model_i.prog[p] = w;
    idt_mem_model_i.prog[p+1] = fill;
    idt_mem_model_i.prog[p+2] = 14'h0000;
    gap = 0;
    run_slot();
    // Two-cycle words fetch twice: at commit and at the end of the discarded slot
    gap = 0;
    rdCnt = 0;
    wrCnt = 0;
    flushCnt = 0;
    adjCnt = 0;
    endCnt = 0;
    seenFlow = idt_pkg::CT_NONE;
    seenSel = 1'bx;
    seenMode = 2'bxx;
    repeat (expFetch) run_slot();
    check_val("slot clocks", 16'(expGap), 16'(gap));
    check_val("cycle ends", 16'(expGap / 4), 16'(endCnt));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic scen_literal();
    logic [13:0] words [6];
    logic [7:0] results [6];
    words = '{{idt_pkg::OP_MOVLW, 8'h5A}, {idt_pkg::OP_ADDLW, 8'h10}, {idt_pkg::OP_ANDLW, 8'h0F},
      {idt_pkg::OP_IORLW, 8'hF0}, {idt_pkg::OP_XORLW, 8'hFF}, {idt_pkg::OP_SUBLW, 8'h07}};
    results = '{8'h5A, 8'h6A, 8'h0A, 8'hFA, 8'h05, 8'h02};
    foreach (words[i]) begin
      issue(words[i], 14'h0000, 4);
      check_data("accumulator", results[i], accum);
    end
  endtask
  task automatic scen_byte();
    idt_mem_model_i.fileMem[7'h7F] = 8'h21;
    issue({idt_pkg::OP_ADDWF, 1'b0, 7'h7F}, 14'h0000, 4);
    check_data("accumulator", 8'h23, accum);
    check_val("file reads", 16'h0001, 16'(rdCnt));
    check_val("file writes", 16'h0000, 16'(wrCnt));
    issue({idt_pkg::OP_ADDWF, 1'b1, 7'h7F}, 14'h0000, 4);
    check_data("file 7F", 8'h44, idt_mem_model_i.fileMem[7'h7F]);
    check_data("accumulator", 8'h23, accum);
    issue({idt_pkg::OP_MOVWF, 1'b1, 7'h10}, 14'h0000, 4);
    check_val("file reads", 16'h0001, 16'(rdCnt));
    check_data("file 10", 8'h23, idt_mem_model_i.fileMem[7'h10]);
  endtask
  task automatic scen_bit();
    for (int b = 0; b < 8; b++) begin
      idt_mem_model_i.fileMem[7'h33] = 8'h00;
      issue({idt_pkg::OP_BITSET, 3'(b), 7'h33}, 14'h0000, 4);
      check_data("bit set", 8'h01 << b, idt_mem_model_i.fileMem[7'h33]);
      idt_mem_model_i.fileMem[7'h34] = 8'hFF;
      issue({idt_pkg::OP_BITCLR, 3'(b), 7'h34}, 14'h0000, 4);
      check_data("bit clear", ~(8'h01 << b), idt_mem_model_i.fileMem[7'h34]);
    end
  endtask
  task automatic scen_skip();
    logic [7:0] prev;
    idt_mem_model_i.fileMem[7'h20] = 8'h08;
    idt_mem_model_i.fileMem[7'h21] = 8'h01;
    idt_mem_model_i.fileMem[7'h22] = 8'hFF;
    prev = accum;
    issue({idt_pkg::OP_SKIPSET, 3'h3, 7'h20}, POISON_WORD, 8, 2);
    check_data("accumulator", prev, accum);
    check_val("flush pulses", 16'h0000, 16'(flushCnt));
    check_val("flow kind", 16'(idt_pkg::CT_NONE), 16'(seenFlow));
    issue({idt_pkg::OP_SKIPCLR, 3'h3, 7'h20}, 14'h0000, 4);
    issue({idt_pkg::OP_DECSKIP, 1'b1, 7'h21}, POISON_WORD, 8, 2);
    check_data("file 21", 8'h00, idt_mem_model_i.fileMem[7'h21]);
    issue({idt_pkg::OP_INCSKIP, 1'b1, 7'h22}, POISON_WORD, 8, 2);
    check_data("accumulator", prev, accum);
  endtask
  task automatic scen_flow();
    logic [13:0] words [8];
    idt_pkg::idt_ctrl_t kinds [8];
    logic [7:0] prev;
    words = '{14'h2005, idt_pkg::OP_CALLACC, idt_pkg::OP_RETURN, {idt_pkg::OP_RETLIT, 8'h55},
      idt_pkg::OP_RETINT, 14'h2805, 14'h3203, idt_pkg::OP_BRANCHACC};
    kinds = '{idt_pkg::CT_CALL, idt_pkg::CT_CALLACC, idt_pkg::CT_RET, idt_pkg::CT_RETLIT,
      idt_pkg::CT_RETINT, idt_pkg::CT_JUMP, idt_pkg::CT_RELBR, idt_pkg::CT_BRACC};
    foreach (words[i]) begin
      prev = (kinds[i] == idt_pkg::CT_RETLIT) ? 8'h55 : accum;
      issue(words[i], POISON_WORD, 8, 2);
      check_val("flush pulses", 16'h0001, 16'(flushCnt));
      check_val("flow kind", 16'(kinds[i]), 16'(seenFlow));
      check_data("accumulator", prev, accum);
    end
  endtask
  task automatic scen_indirect();
    idt_mem_model_i.fileMem[7'h00] = 8'h3C;
    idt_mem_model_i.fileMem[7'h01] = 8'hC3;
    ptrInProg = 2'b01;
    issue({idt_pkg::OP_MOVF, 1'b0, idt_pkg::IND_REG0_ADDR}, 14'h0000, 8);
    check_data("accumulator", 8'h3C, accum);
    ptrInProg = 2'b10;
    issue({idt_pkg::OP_MOVF, 1'b0, idt_pkg::IND_REG0_ADDR}, 14'h0000, 4);
    issue({idt_pkg::OP_MOVF, 1'b0, idt_pkg::IND_REG1_ADDR}, 14'h0000, 8);
    check_data("accumulator", 8'hC3, accum);
    ptrInProg = 2'b00;
  endtask
  task automatic scen_pointer();
    for (int n = 0; n < 2; n++) begin
      for (int m = 0; m < 4; m++) begin
        issue(14'h0010 | 14'(n << 2) | 14'(m), 14'h0000, 4);
        check_val("pointer adjusts", 16'h0001, 16'(adjCnt));
        check_val("pointer number", 16'(n), 16'(seenSel));
        check_val("pointer mode", 16'(m), 16'(seenMode));
      end
    end
  endtask
  task automatic scen_dont_care();
    issue({idt_pkg::OP_MOVLW, 8'h77}, 14'h0000, 4);
    issue(14'h0100, 14'h0000, 4);
    check_data("accumulator", 8'h00, accum);
    issue({idt_pkg::OP_MOVLW, 8'h77}, 14'h0000, 4);
    issue(14'h0103, 14'h0000, 4);
    check_data("accumulator", 8'h00, accum);
    check_val("file writes", 16'h0000, 16'(wrCnt));
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    scen_literal();
    scen_byte();
    scen_bit();
    scen_skip();
    scen_flow();
    scen_indirect();
    scen_pointer();
    scen_dont_care();
    close_out();
  end
endmodule
